// File: verilog/ddr_phy_cal_defs.svh
// Purpose: offsets, field positions, reset values and timing counts of the phy/calibration bank
// Assumes: 32-bit axi4-lite register bus, one aligned word per register
// Notes: included by bare name; definitions only
`ifndef DDR_PHY_CAL_DEFS_SVH
`define DDR_PHY_CAL_DEFS_SVH

// register byte offsets
`define PHY_CTRL_OFS 8'h00
`define CAL_CTRL_OFS 8'h04

// phy_control_one field positions
`define PHY_SGS_BIT 7
`define PHY_RXPD_BIT 6
`define PHY_RL_MSB 2
`define PHY_RL_LSB 0
`define PHY_CTRL_RESET 32'h0000_0000

// io_calibration_control field positions
`define CAL_REFSEL_BIT 18
`define CAL_LEVEL_MSB 17
`define CAL_LEVEL_LSB 16
`define CAL_READY_BIT 15
`define CAL_GATE_BIT 14
`define CAL_CLRN_BIT 13
`define CAL_FPW_BIT 12
`define CAL_FNW_BIT 11
`define CAL_FPS_BIT 10
`define CAL_FNS_BIT 9
`define CAL_SAVER_BIT 8
`define CAL_LOCK_BIT 7
`define CAL_OFF_BIT 6
`define CAL_DRIVE_MSB 5
`define CAL_DRIVE_LSB 3
`define CAL_FILT_MSB 2
`define CAL_FILT_LSB 0
`define CAL_CTRL_RESET 32'h0000_0077

// axi response codes
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// calibration settle time and its cycle count at the 40 ns clock
`define CLK_PERIOD_NS 40
`define CAL_SETTLE_NS 2000
`define CAL_SETTLE_CYCLES ((`CAL_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// File: verilog/ddr_phy_cal_pkg.sv
// Purpose: types shared by the phy/calibration control bank
// Assumes: field layout as in ddr_phy_cal_defs.svh
// Notes: types only; numbers live in the header
package ddr_phy_cal_pkg;

   // software view of phy_control_one
   typedef struct packed {
      logic strobe_gate_source;
      logic rx_idle_powerdown;
      logic [2:0] read_latency_cycles;
   } phy_ctrl_t;

   // software view of io_calibration_control, ready excluded
   typedef struct packed {
      logic internal_ref_select;
      logic [1:0] ref_level_select;
      logic input_buffer_pd_gate;
      logic cal_flop_clear_n;
      logic force_pside_weaker;
      logic force_nside_weaker;
      logic force_pside_stronger;
      logic force_nside_stronger;
      logic cal_resistor_saver;
      logic impedance_lock;
      logic cal_unit_off;
      logic [2:0] drive_code;
      logic [2:0] filter_code;
   } cal_ctrl_t;

   // impedance calibration sequencer
   typedef enum logic [2:0] {
      CAL_IDLE = 3'h1,
      CAL_RUN = 3'h2,
      CAL_DONE = 3'h4
   } cal_state_t;

endpackage : ddr_phy_cal_pkg

// File: verilog/ddr_phy_and_io_cal_control.sv
// Purpose: axi4-lite register bank for ddr phy read control and io impedance calibration
// Assumes: aclk is also the memory clock; inputs synchronous to aclk
// Notes: two registers, unmapped addresses answer slverr
`timescale 1ns/1ps
`include "ddr_phy_cal_defs.svh"

module ddr_phy_and_io_cal_control (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address
   input wire logic s_axil_awvalid,
   output logic s_axil_awready,
   input wire logic [7:0] s_axil_awaddr,
   input wire logic [2:0] s_axil_awprot,
   // axi4-lite write data
   input wire logic s_axil_wvalid,
   output logic s_axil_wready,
   input wire logic [31:0] s_axil_wdata,
   input wire logic [3:0] s_axil_wstrb,
   // axi4-lite write response
   output logic s_axil_bvalid,
   input wire logic s_axil_bready,
   output logic [1:0] s_axil_bresp,
   // axi4-lite read address
   input wire logic s_axil_arvalid,
   output logic s_axil_arready,
   input wire logic [7:0] s_axil_araddr,
   input wire logic [2:0] s_axil_arprot,
   // axi4-lite read data
   output logic s_axil_rvalid,
   input wire logic s_axil_rready,
   output logic [31:0] s_axil_rdata,
   output logic [1:0] s_axil_rresp,
   // phy read path
   input wire logic read_issue,
   input wire logic ext_strobe_gate,
   output logic read_capture,
   output logic strobe_gate_en,
   output logic rx_powered_down,
   // io reference
   output logic ref_internal,
   output logic [1:0] ref_level,
   // impedance calibration
   output logic [3:0] drive_force,
   output logic resistor_current_on,
   output logic cal_ready,
   output logic impedance_hold,
   output logic [2:0] drive_code,
   output logic [2:0] filter_code
);

   // register contents and calibration sequencer state
   ddr_phy_cal_pkg::phy_ctrl_t phy_ctrl;
   ddr_phy_cal_pkg::cal_ctrl_t cal_ctrl;
   ddr_phy_cal_pkg::cal_state_t cal_state;
   logic [7:0] settle_count;

   // write channel state, plus the read handshake flags
   logic aw_hold;
   logic w_hold;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic do_write;
   logic next_aw_hold;
   logic next_w_hold;
   logic next_bvalid;
   logic next_rvalid;
   logic aw_take;
   logic w_take;
   logic ar_take;

   // read path state
   logic [7:0] read_pipe;
   logic read_active;

   // one-hot register select: bit 0 phy_control_one, bit 1 io_calibration_control
   function automatic logic [1:0] reg_select(input logic [7:0] addr);
      logic [1:0] sel;
      sel = 2'h0;
      if (addr == `PHY_CTRL_OFS) begin
         sel = 2'h1;
      end else if (addr == `CAL_CTRL_OFS) begin
         sel = 2'h2;
      end
      return sel;
   endfunction : reg_select

   // byte-lane merge of a write into the current word
   function automatic logic [31:0] lane_merge(input logic [31:0] old_word,
                                              input logic [31:0] new_word,
                                              input logic [3:0] strb);
      logic [31:0] word;
      word = old_word;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            word[i*8 +: 8] = new_word[i*8 +: 8];
         end
      end
      return word;
   endfunction : lane_merge

   // word images of the registers; reserved bits stay zero
   function automatic logic [31:0] phy_word(input ddr_phy_cal_pkg::phy_ctrl_t p);
      logic [31:0] word;
      word = 32'h0000_0000;
      word[`PHY_SGS_BIT] = p.strobe_gate_source;
      word[`PHY_RXPD_BIT] = p.rx_idle_powerdown;
      word[`PHY_RL_MSB:`PHY_RL_LSB] = p.read_latency_cycles;
      return word;
   endfunction : phy_word

   function automatic logic [31:0] cal_word(input ddr_phy_cal_pkg::cal_ctrl_t c,
                                            input logic ready);
      logic [31:0] word;
      word = 32'h0000_0000;
      word[`CAL_REFSEL_BIT] = c.internal_ref_select;
      word[`CAL_LEVEL_MSB:`CAL_LEVEL_LSB] = c.ref_level_select;
      word[`CAL_READY_BIT] = ready;
      word[`CAL_GATE_BIT] = c.input_buffer_pd_gate;
      word[`CAL_CLRN_BIT] = c.cal_flop_clear_n;
      word[`CAL_FPW_BIT] = c.force_pside_weaker;
      word[`CAL_FNW_BIT] = c.force_nside_weaker;
      word[`CAL_FPS_BIT] = c.force_pside_stronger;
      word[`CAL_FNS_BIT] = c.force_nside_stronger;
      word[`CAL_SAVER_BIT] = c.cal_resistor_saver;
      word[`CAL_LOCK_BIT] = c.impedance_lock;
      word[`CAL_OFF_BIT] = c.cal_unit_off;
      word[`CAL_DRIVE_MSB:`CAL_DRIVE_LSB] = c.drive_code;
      word[`CAL_FILT_MSB:`CAL_FILT_LSB] = c.filter_code;
      return word;
   endfunction : cal_word

   // stored fields of a word image; struct field order follows the bit layout
   function automatic ddr_phy_cal_pkg::phy_ctrl_t phy_fields(input logic [31:0] w);
      return {w[`PHY_SGS_BIT:`PHY_RXPD_BIT], w[`PHY_RL_MSB:`PHY_RL_LSB]};
   endfunction : phy_fields

   // ready (bit 15) and reserved bits fall out here, so writes cannot reach them
   function automatic ddr_phy_cal_pkg::cal_ctrl_t cal_fields(input logic [31:0] w);
      return {w[`CAL_REFSEL_BIT:`CAL_LEVEL_LSB], w[`CAL_GATE_BIT:`CAL_FILT_LSB]};
   endfunction : cal_fields

   // handshakes and next values of the channel flags
   always_comb begin
      aw_take = s_axil_awvalid & s_axil_awready;
      w_take = s_axil_wvalid & s_axil_wready;
      ar_take = s_axil_arvalid & s_axil_arready;
      do_write = aw_hold & w_hold & ~s_axil_bvalid;
      next_aw_hold = (aw_hold | aw_take) & ~do_write;
      next_w_hold = (w_hold | w_take) & ~do_write;
      next_bvalid = do_write | (s_axil_bvalid & ~s_axil_bready);
      next_rvalid = ar_take | (s_axil_rvalid & ~s_axil_rready);
   end

   // write address and data are taken in either order and held until both are in
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold <= 1'b0;
         w_hold <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_axil_awready <= 1'b0;
         s_axil_wready <= 1'b0;
      end else begin
         aw_hold <= next_aw_hold;
         w_hold <= next_w_hold;
         if (aw_take) begin
            aw_addr <= s_axil_awaddr;
         end
         if (w_take) begin
            w_data <= s_axil_wdata;
            w_strb <= s_axil_wstrb;
         end
         // no new beat is accepted while a response is still owed
         s_axil_awready <= ~next_aw_hold & ~next_bvalid;
         s_axil_wready <= ~next_w_hold & ~next_bvalid;
      end
   end

   // write response: slverr for an address outside the bank
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axil_bvalid <= 1'b0;
         s_axil_bresp <= `RESP_OKAY;
      end else begin
         s_axil_bvalid <= next_bvalid;
         if (do_write) begin
            s_axil_bresp <= (reg_select(aw_addr) == 2'h0) ? `RESP_SLVERR : `RESP_OKAY;
         end
      end
   end

   // register update; only defined fields are stored, so reserved bits ignore writes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         phy_ctrl <= phy_fields(`PHY_CTRL_RESET);
         cal_ctrl <= cal_fields(`CAL_CTRL_RESET);
      end else if (do_write && reg_select(aw_addr) == 2'h1) begin
         phy_ctrl <= phy_fields(lane_merge(phy_word(phy_ctrl), w_data, w_strb));
      end else if (do_write && reg_select(aw_addr) == 2'h2) begin
         cal_ctrl <= cal_fields(lane_merge(cal_word(cal_ctrl, 1'b0), w_data, w_strb));
      end
   end

   // read channel: data sampled at the address handshake, answered one cycle later
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axil_arready <= 1'b0;
         s_axil_rvalid <= 1'b0;
         s_axil_rdata <= 32'h0000_0000;
         s_axil_rresp <= `RESP_OKAY;
      end else begin
         s_axil_arready <= ~next_rvalid;
         s_axil_rvalid <= next_rvalid;
         if (ar_take) begin
            case (reg_select(s_axil_araddr))
               2'h1: begin
                  s_axil_rdata <= phy_word(phy_ctrl);
                  s_axil_rresp <= `RESP_OKAY;
               end
               2'h2: begin
                  s_axil_rdata <= cal_word(cal_ctrl, cal_ready);
                  s_axil_rresp <= `RESP_OKAY;
               end
               default: begin
                  s_axil_rdata <= 32'h0000_0000;
                  s_axil_rresp <= `RESP_SLVERR;
               end
            endcase
         end
      end
   end

   // read capture delay line; software keeps the latency in the legal window
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         read_pipe <= 8'h00;
         read_capture <= 1'b0;
      end else begin
         read_pipe <= {read_pipe[6:0], read_issue};
         read_capture <= read_pipe[phy_ctrl.read_latency_cycles];
      end
   end

   // a read is in flight from its issue until it shifts out of the last of the eight delay stages
   assign read_active = read_issue | (|read_pipe);

   // strobe gating and idle receiver power-down
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         strobe_gate_en <= 1'b0;
         rx_powered_down <= 1'b0;
      end else begin
         // internal gating opens for the whole read window
         strobe_gate_en <= phy_ctrl.strobe_gate_source ? ext_strobe_gate : read_active;
         rx_powered_down <= cal_ctrl.input_buffer_pd_gate
                            & phy_ctrl.rx_idle_powerdown & ~read_active;
      end
   end

   // calibration sequencer; a stored clear bit of zero holds its flops cleared
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cal_state <= ddr_phy_cal_pkg::CAL_IDLE;
         settle_count <= 8'h00;
      end else if (!cal_ctrl.cal_flop_clear_n) begin
         cal_state <= ddr_phy_cal_pkg::CAL_IDLE;
         settle_count <= 8'h00;
      end else begin
         case (cal_state)
            ddr_phy_cal_pkg::CAL_IDLE: begin
               settle_count <= 8'h00;
               if (!cal_ctrl.cal_unit_off) begin
                  cal_state <= ddr_phy_cal_pkg::CAL_RUN;
               end
            end
            ddr_phy_cal_pkg::CAL_RUN: begin
               if (cal_ctrl.cal_unit_off) begin
                  cal_state <= ddr_phy_cal_pkg::CAL_IDLE;
               end else if (settle_count == 8'(`CAL_SETTLE_CYCLES - 1)) begin
                  cal_state <= ddr_phy_cal_pkg::CAL_DONE;
               end else begin
                  settle_count <= settle_count + 8'h01;
               end
            end
            ddr_phy_cal_pkg::CAL_DONE: begin
               // a locked impedance survives power-down of the unit
               if (cal_ctrl.cal_unit_off && !cal_ctrl.impedance_lock) begin
                  cal_state <= ddr_phy_cal_pkg::CAL_IDLE;
               end
            end
            default: begin
               cal_state <= ddr_phy_cal_pkg::CAL_IDLE;
            end
         endcase
      end
   end

   // ready flag and resistor current
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cal_ready <= 1'b0;
         resistor_current_on <= 1'b0;
      end else begin
         cal_ready <= (cal_state == ddr_phy_cal_pkg::CAL_DONE);
         // with the saver set, current flows only while the sequencer measures
         resistor_current_on <= ~cal_ctrl.cal_unit_off
                                & (~cal_ctrl.cal_resistor_saver
                                   | (cal_state == ddr_phy_cal_pkg::CAL_RUN));
      end
   end

   // static controls straight from the register flops
   assign ref_internal = cal_ctrl.internal_ref_select;
   assign ref_level = cal_ctrl.ref_level_select;
   assign drive_force = {cal_ctrl.force_pside_weaker, cal_ctrl.force_nside_weaker,
                         cal_ctrl.force_pside_stronger, cal_ctrl.force_nside_stronger};
   assign impedance_hold = cal_ctrl.impedance_lock;
   assign drive_code = cal_ctrl.drive_code;
   assign filter_code = cal_ctrl.filter_code;

endmodule : ddr_phy_and_io_cal_control

// File: test/ddr_phy_cal_checker.sv
// Purpose: port-level assertions for the phy/calibration register bank
// Assumes: full-word writes; the shadows below ignore wstrb
// Notes: register state is rebuilt from bus handshakes seen at the ports
`timescale 1ns/1ps
`include "ddr_phy_cal_defs.svh"

module ddr_phy_cal_checker (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // register bus
   input wire logic s_axil_awvalid,
   input wire logic s_axil_awready,
   input wire logic [7:0] s_axil_awaddr,
   input wire logic s_axil_wvalid,
   input wire logic s_axil_wready,
   input wire logic [31:0] s_axil_wdata,
   input wire logic s_axil_bvalid,
   input wire logic [1:0] s_axil_bresp,
   input wire logic s_axil_arvalid,
   input wire logic s_axil_arready,
   input wire logic [7:0] s_axil_araddr,
   input wire logic s_axil_rvalid,
   input wire logic [1:0] s_axil_rresp,
   // phy and calibration
   input wire logic read_issue,
   input wire logic ext_strobe_gate,
   input wire logic read_capture,
   input wire logic strobe_gate_en,
   input wire logic rx_powered_down,
   input wire logic ref_internal,
   input wire logic [1:0] ref_level,
   input wire logic [3:0] drive_force,
   input wire logic resistor_current_on,
   input wire logic cal_ready
);
   logic [7:0] aw_a;
   logic [31:0] w_d, phy_sh, cal_sh, phy_now, cal_now;
   logic [9:0] hist;
   logic bv_q;
   logic upd;
   logic [1:0] wr_code, rd_code;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // address and data as taken; only read once a response has risen
   always_ff @(posedge aclk) begin
      if (s_axil_awvalid && s_axil_awready) aw_a <= s_axil_awaddr;
      if (s_axil_wvalid && s_axil_wready) w_d <= s_axil_wdata;
   end

   // response edge detect and read issue history
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bv_q <= 1'b0;
         hist <= 10'h000;
         phy_sh <= `PHY_CTRL_RESET;
         cal_sh <= `CAL_CTRL_RESET;
      end else begin
         bv_q <= s_axil_bvalid;
         hist <= {hist[8:0], read_issue};
         phy_sh <= phy_now;
         cal_sh <= cal_now;
      end
   end

   // register contents as they stand after the edge where bvalid rose
   assign upd = s_axil_bvalid && !bv_q;
   assign phy_now = (upd && aw_a == `PHY_CTRL_OFS) ? (w_d & 32'h0000_00C7) : phy_sh;
   assign cal_now = (upd && aw_a == `CAL_CTRL_OFS) ? (w_d & 32'h0007_7FFF) : cal_sh;
   assign wr_code = (s_axil_awaddr == `PHY_CTRL_OFS || s_axil_awaddr == `CAL_CTRL_OFS) ?
      `RESP_OKAY : `RESP_SLVERR;
   assign rd_code = (s_axil_araddr == `PHY_CTRL_OFS || s_axil_araddr == `CAL_CTRL_OFS) ?
      `RESP_OKAY : `RESP_SLVERR;

   sequence wr_taken;
      s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready;
   endsequence
   sequence rd_taken;
      s_axil_arvalid && s_axil_arready;
   endsequence

   AST_WR_RESP: assert property (wr_taken |-> ##2 (s_axil_bvalid &&
      s_axil_bresp == $past(wr_code, 2))) else $error("write response late or wrong");
   AST_RD_RESP: assert property (rd_taken |=> (s_axil_rvalid &&
      s_axil_rresp == $past(rd_code))) else $error("read response late or wrong");
   AST_CAPTURE_LAT: assert property (read_capture |->
      (hist[{1'b0, phy_now[2:0]} + 4'h1] || hist[{1'b0, phy_now[2:0]} + 4'h2]))
      else $error("capture strobe not at programmed latency");
   AST_GATE_EXT: assert property ($past(phy_now[7]) |->
      strobe_gate_en == $past(ext_strobe_gate)) else $error("external gating not followed");
   AST_RX_PD: assert property (rx_powered_down |->
      $past(phy_now[6] && cal_now[14] && !read_issue)) else $error("receivers off wrongly");
   AST_REF_ROUTE: assert property (ref_internal == cal_now[18] &&
      ref_level == cal_now[17:16]) else $error("reference routing mismatch");
   AST_FORCE: assert property (drive_force == cal_now[12:9])
      else $error("drive override mismatch");
   AST_SAVER_ON: assert property ($past(!cal_now[6] && !cal_now[8]) |->
      resistor_current_on) else $error("resistor current off without saver");
   AST_UNIT_OFF: assert property (resistor_current_on |-> $past(!cal_now[6]))
      else $error("resistor current on while unit off");
   AST_READY_CLR: assert property (cal_ready |-> $past(cal_now[13], 2))
      else $error("ready while calibration held clear");
endmodule : ddr_phy_cal_checker

bind ddr_phy_and_io_cal_control ddr_phy_cal_checker chk (.*);

// File: test/ddr_mem_model.sv
// Purpose: far-side memory stand-in that returns an external strobe window
// Assumes: strobe window opens the column latency plus two cycles after each read issue
// Notes: two-cycle window; no strobe outside it
`timescale 1ns/1ps

module ddr_mem_model (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // read traffic
   input wire logic read_issue,
   input wire logic [2:0] cas_lat,
   output logic ext_strobe_gate
);
   logic [9:0] pipe;

   // issue history, one bit per memory clock
   always_ff @(posedge aclk) begin
      if (!aresetn) pipe <= 10'h000;
      else pipe <= {pipe[8:0], read_issue};
   end

   // strobe preamble window; low when idle so a stale level never shows
   always_ff @(posedge aclk) begin
      ext_strobe_gate <= aresetn && (pipe[cas_lat] || pipe[{1'b0, cas_lat} + 4'h1]);
   end
endmodule : ddr_mem_model

// File: test/ddr_phy_and_io_cal_control_tb.sv
// Purpose: self-checking bench for the phy/calibration register bank
// Assumes: drive after rising edges; ready flags sampled at rising edges, results at falling edges
// Notes: column latency handed to the memory model tracks the programmed latency
`timescale 1ns/1ps
`include "ddr_phy_cal_defs.svh"

module ddr_phy_and_io_cal_control_tb;
   logic aclk, aresetn, s_axil_awvalid, s_axil_awready, s_axil_wvalid, s_axil_wready;
   logic s_axil_bvalid, s_axil_bready, s_axil_arvalid, s_axil_arready, s_axil_rvalid;
   logic s_axil_rready, read_issue, ext_strobe_gate, read_capture, strobe_gate_en;
   logic rx_powered_down, ref_internal, resistor_current_on, cal_ready, impedance_hold;
   logic [7:0] s_axil_awaddr, s_axil_araddr;
   logic [2:0] s_axil_awprot, s_axil_arprot, drive_code, filter_code, cas_lat;
   logic [31:0] s_axil_wdata, s_axil_rdata;
   logic [3:0] s_axil_wstrb, drive_force;
   logic [1:0] s_axil_bresp, s_axil_rresp, ref_level;
   int err_total, comparisons;

   ddr_phy_and_io_cal_control dut (.*);
   ddr_mem_model mem (.aclk(aclk), .aresetn(aresetn), .read_issue(read_issue),
      .cas_lat(cas_lat), .ext_strobe_gate(ext_strobe_gate));

   // 25 MHz clock
   always #20 aclk = ~aclk;

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // write: address and data offered together, bready held until bvalid
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      {s_axil_awvalid, s_axil_wvalid, s_axil_bready} <= 3'h7;
      s_axil_awaddr <= a;
      s_axil_wdata <= d;
      // ready is read before the edge updates it, so each valid drops at its handshake
      do begin
         @(posedge aclk);
         if (s_axil_awready) s_axil_awvalid <= 1'b0;
         if (s_axil_wready) s_axil_wvalid <= 1'b0;
         @(negedge aclk);
      end while (s_axil_awvalid || s_axil_wvalid);
      while (!s_axil_bvalid) @(negedge aclk);
      chk("bresp", {30'h0, er}, {30'h0, s_axil_bresp});
      @(posedge aclk);
      s_axil_bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge aclk);
      {s_axil_arvalid, s_axil_rready} <= 2'h3;
      s_axil_araddr <= a;
      do @(posedge aclk); while (!s_axil_arready);
      s_axil_arvalid <= 1'b0;
      while (!s_axil_rvalid) @(negedge aclk);
      chk("rdata", e, s_axil_rdata);
      chk("rresp", {30'h0, er}, {30'h0, s_axil_rresp});
      @(posedge aclk);
      s_axil_rready <= 1'b0;
   endtask : rd

   task automatic issue();
      @(posedge aclk);
      read_issue <= 1'b1;
      @(posedge aclk);
      read_issue <= 1'b0;
   endtask : issue

   task automatic t_regs();
      rd(`PHY_CTRL_OFS, `PHY_CTRL_RESET, `RESP_OKAY);
      rd(`CAL_CTRL_OFS, `CAL_CTRL_RESET, `RESP_OKAY);
      rd(8'h08, 32'h0000_0000, `RESP_SLVERR);
      wr(8'h0C, 32'hFFFF_FFFF, `RESP_SLVERR);
      wr(`PHY_CTRL_OFS, 32'hFFFF_FFFF, `RESP_OKAY);
      rd(`PHY_CTRL_OFS, 32'h0000_00C7, `RESP_OKAY);
      wr(`CAL_CTRL_OFS, 32'hFFFF_FFFF, `RESP_OKAY);
      rd(`CAL_CTRL_OFS, 32'h0007_7FFF, `RESP_OKAY);
      chk("lock drive filter", 32'h7F, {25'h0, impedance_hold, drive_code, filter_code});
      wr(`CAL_CTRL_OFS, `CAL_CTRL_RESET, `RESP_OKAY);
      wr(`PHY_CTRL_OFS, `PHY_CTRL_RESET, `RESP_OKAY);
   endtask : t_regs

   // latency settings 1 to 7; the fixed pipeline offset must not change
   task automatic t_latency();
      int d, d0;
      d0 = 0;
      for (int lat = 1; lat < 8; lat++) begin
         cas_lat <= 3'(lat - 1);
         wr(`PHY_CTRL_OFS, 32'(lat), `RESP_OKAY);
         issue();
         d = 0;
         do begin @(negedge aclk); d++; end while (!read_capture);
         if (lat == 1) d0 = d - 1;
         chk("capture delay", 32'(d0 + lat), 32'(d));
         @(negedge aclk);
         chk("capture pulse", 32'h0, {31'h0, read_capture});
      end
      chk("capture offset", 32'h1, {31'h0, d0 == 1 || d0 == 2});
   endtask : t_latency

   task automatic t_gate();
      logic seen;
      seen = 1'b0;
      wr(`PHY_CTRL_OFS, 32'h0000_0007, `RESP_OKAY);
      issue();
      @(negedge aclk);
      chk("internal gate", 32'h1, {31'h0, strobe_gate_en});
      repeat (13) @(negedge aclk);
      chk("internal gate idle", 32'h0, {31'h0, strobe_gate_en});
      cas_lat <= 3'h3;
      wr(`PHY_CTRL_OFS, 32'h0000_0084, `RESP_OKAY);
      issue();
      @(negedge aclk);
      chk("external gate early", 32'h0, {31'h0, strobe_gate_en});
      repeat (14) begin @(negedge aclk); seen = seen | strobe_gate_en; end
      chk("external gate seen", 32'h1, {31'h0, seen});
      chk("external gate idle", 32'h0, {31'h0, strobe_gate_en});
   endtask : t_gate

   task automatic t_rxpd();
      wr(`PHY_CTRL_OFS, 32'h0000_0044, `RESP_OKAY);
      repeat (3) @(negedge aclk);
      chk("rx pd ungated", 32'h0, {31'h0, rx_powered_down});
      wr(`CAL_CTRL_OFS, 32'h0000_4077, `RESP_OKAY);
      repeat (3) @(negedge aclk);
      chk("rx pd idle", 32'h1, {31'h0, rx_powered_down});
      issue();
      @(negedge aclk);
      chk("rx pd reading", 32'h0, {31'h0, rx_powered_down});
      repeat (20) @(negedge aclk);
      chk("rx pd after read", 32'h1, {31'h0, rx_powered_down});
      wr(`PHY_CTRL_OFS, 32'h0000_0004, `RESP_OKAY);
      repeat (3) @(negedge aclk);
      chk("rx pd off", 32'h0, {31'h0, rx_powered_down});
   endtask : t_rxpd

   // reference routes and levels, then each drive override alone
   task automatic t_ref_force();
      for (int i = 0; i < 8; i++) begin
         wr(`CAL_CTRL_OFS, 32'h0000_0077 | (32'(i) << 16), `RESP_OKAY);
         @(negedge aclk);
         chk("ref internal", 32'(i >> 2), {31'h0, ref_internal});
         chk("ref level", 32'(i & 3), {30'h0, ref_level});
      end
      for (int i = 0; i < 4; i++) begin
         wr(`CAL_CTRL_OFS, 32'h0000_0077 | (32'h1 << (9 + i)), `RESP_OKAY);
         @(negedge aclk);
         chk("drive force", 32'h1 << i, {28'h0, drive_force});
      end
   endtask : t_ref_force

   task automatic t_cal();
      int n;
      logic [31:0] tbl [4];
      n = 0;
      wr(`CAL_CTRL_OFS, 32'h0000_2000, `RESP_OKAY);
      do begin @(negedge aclk); n++; end while (!cal_ready);
      chk("ready time", 32'h1, {31'h0, n >= 48 && n <= 56});
      rd(`CAL_CTRL_OFS, 32'h0000_A000, `RESP_OKAY);
      wr(`CAL_CTRL_OFS, 32'h0000_8000, `RESP_OKAY);
      repeat (2) @(negedge aclk);
      chk("ready cleared", 32'h0, {31'h0, cal_ready});
      rd(`CAL_CTRL_OFS, 32'h0000_0000, `RESP_OKAY);
      // saver and unit-off pairs with the resistor current each implies
      tbl = '{32'h0000_0100, 32'h0000_0000, 32'h0000_0140, 32'h0000_0040};
      for (int i = 0; i < 4; i++) begin
         wr(`CAL_CTRL_OFS, tbl[i], `RESP_OKAY);
         repeat (2) @(negedge aclk);
         chk("resistor current", 32'(i == 1), {31'h0, resistor_current_on});
      end
   endtask : t_cal

   task automatic results();
      $display("checks %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : results

   // main sequence
   initial begin
      {aclk, aresetn, s_axil_awvalid, s_axil_wvalid, s_axil_bready} = 5'h0;
      {s_axil_arvalid, s_axil_rready, read_issue} = 3'h0;
      {s_axil_awaddr, s_axil_araddr, s_axil_awprot, s_axil_arprot, cas_lat} = 25'h0;
      s_axil_wdata = 32'h0;
      s_axil_wstrb = 4'hF;
      err_total = 0;
      comparisons = 0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs();
      t_latency();
      t_gate();
      t_rxpd();
      t_ref_force();
      t_cal();
      results();
   end

   // hang guard, far beyond the few hundred cycles the run needs
   initial begin
      repeat (20000) @(posedge aclk);
      err_total++;
      results();
   end
endmodule : ddr_phy_and_io_cal_control_tb
